// ---- inc/ost_pkg.sv ----
package ost_pkg;

   // Register offsets on the byte-wide register port.
   localparam logic [15:0] OFS_TIMER_CTRL    = 16'h0108;
   localparam logic [15:0] OFS_SHOT_CTRL     = 16'h0109;
   localparam logic [15:0] OFS_PIN_CTRL      = 16'h010A;
   localparam logic [15:0] OFS_MODE          = 16'h010B;
   localparam logic [15:0] OFS_PRESCALER     = 16'h010C;
   localparam logic [15:0] OFS_SECONDARY     = 16'h010D;
   localparam logic [15:0] OFS_PRIMARY       = 16'h010E;

   // Field positions in timer_control_reg.
   localparam int BIT_COUNT_START   = 0;
   localparam int BIT_COUNT_RUNNING = 1;
   localparam int BIT_FORCED_STOP   = 2;

   // Field positions in shot_control_reg.
   localparam int BIT_SHOT_START    = 0;
   localparam int BIT_SHOT_STOP     = 1;
   localparam int BIT_SHOT_BUSY     = 2;

   // Field positions in timer_pin_control.
   localparam int BIT_OUT_LEVEL     = 0;
   localparam int BIT_OUT_SWITCH    = 1;
   localparam int BIT_PIN_TRIG_EN   = 2;
   localparam int BIT_TRIG_EDGE     = 3;
   localparam logic [7:0] PIN_CTRL_MASK = 8'h0F;

   // Field positions in the mode register.
   localparam int BIT_WAIT_MODE     = 0;
   localparam int BIT_SRC_LO        = 4;
   localparam int BIT_SRC_HI        = 5;

   // Reset values.
   localparam logic [7:0] RST_PIN_CTRL  = 8'h00;
   localparam logic [7:0] RST_MODE      = 8'h00;
   localparam logic [7:0] RST_COUNT     = 8'hFF;

   // Count source choices and divider ratios.
   localparam logic [1:0] SRC_F1        = 2'h0;
   localparam logic [1:0] SRC_F2        = 2'h1;
   localparam logic [1:0] SRC_F8        = 2'h2;
   localparam logic [1:0] SRC_COMPANION = 2'h3;
   localparam logic [2:0] DIV2_LAST     = 3'h1;
   localparam logic [2:0] DIV8_LAST     = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SYNC  = 3'b001,
      ST_START = 3'b010,
      ST_WAIT  = 3'b011,
      ST_PULSE = 3'b100
   } ost_state_t;

endpackage

// ---- verilog/ost_cs_gen.sv ----
`timescale 1ns/1ps
// Count source tick generator: one enable pulse per count source period.
module ost_cs_gen (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // Selection
   input  wire logic [1:0] src_sel,
   input  wire logic       companion_uf,
   // Tick
   output logic            cs_tick
);

   logic [2:0] div_r;
   logic [2:0] div_nxt;
   logic       tick_f2;
   logic       tick_f8;

   assign div_nxt = div_r + 3'h1;
   assign tick_f2 = (div_r[0] == ost_pkg::DIV2_LAST[0]);
   assign tick_f8 = (div_r == ost_pkg::DIV8_LAST);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_nxt;
      end
   end

   always_comb begin
      case (src_sel)
         ost_pkg::SRC_F1:        cs_tick = 1'b1;
         ost_pkg::SRC_F2:        cs_tick = tick_f2;
         ost_pkg::SRC_F8:        cs_tick = tick_f8;
         ost_pkg::SRC_COMPANION: cs_tick = companion_uf;
         default:                cs_tick = 1'b0;
      endcase
   end

endmodule

// ---- verilog/ost_timer.sv ----
// What this block does
// - Output level bit 0 gives high pulse, low idle; bit 1 gives low pulse, high idle.
// - Pin trigger enable at 1 lets trigger pin edges start a shot; 0 blocks them.
// - Trigger edge select picks falling edge at 0, rising edge at 1.
// - Pin control bits four to seven read as zero.
// - A shot begins only if a trigger arrives while the count running flag is 1.
// - Triggers are a software start bit write or a qualified trigger pin edge.
// - In-progress flag sets two source ticks after trigger; plain mode then pulses.
// - Triggers arriving while a shot is in progress are ignored.
// - Wait mode first counts the wait interval, not the pulse.
// - Trigger edge select never affects the pin interrupt edge outputs.
// - Pin edges during a shot leave the timer alone but still reach interrupt logic.
// - Wait mode waits the primary length, then pulses the secondary length.
// - Count source is f1, f2, f8 or a companion timer underflow.
// - Wait mode counts primary, then loads secondary on underflow and keeps counting.
// - Secondary underflow reloads primary, ends the shot, clears in-progress flag.
// - Whenever counting stops the counter is reloaded from the reload registers.
// - Wait lasts (prescaler+1) times (primary+1) source periods.
// - Wait mode pulse lasts (prescaler+1) times (secondary+1) source periods.
// - Plain mode pulse lasts (prescaler+1) times (primary+1) source periods.
// - Timer request pulses at the final underflow, together with the pulse end.
// - Shot stop, count start cleared or forced stop halt counting.
`timescale 1ns/1ps
module ost_timer (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Count source from the companion timer
   input  wire logic        companion_uf,
   // Pins
   input  wire logic        external_trigger_pin,
   output logic             pulse_output_pin,
   // Towards the pin interrupt logic and the interrupt controller
   output logic             pin_rise_pulse,
   output logic             pin_fall_pulse,
   output logic             timer_irq
);

   // Software visible state.
   logic [7:0]              pin_ctrl_r;
   logic [7:0]              mode_r;
   logic                    count_start_r;
   logic                    count_running_r;
   logic [7:0]              pre_rl_r;
   logic [7:0]              pri_rl_r;
   logic [7:0]              sec_rl_r;
   logic [7:0]              pre_cnt_r;
   logic [7:0]              cnt_r;
   logic [7:0]              rdata_r;
   ost_pkg::ost_state_t     state_r;
   ost_pkg::ost_state_t     state_nxt;
   logic                    pulse_r;
   logic                    irq_r;

   // Trigger pin synchroniser and edge detector.
   logic                    pin_s1_r;
   logic                    pin_s2_r;
   logic                    pin_d_r;

   // Decoded accesses.
   logic                    wr_ctrl;
   logic                    wr_shot;
   logic                    wr_pin;
   logic                    wr_mode;
   logic                    wr_pre;
   logic                    wr_sec;
   logic                    wr_pri;
   logic                    sw_trig;
   logic                    sw_stop;
   logic                    halt;
   logic                    in_prog;
   logic                    cs_tick;
   logic                    step;
   logic                    pre_zero;
   logic                    cnt_zero;
   logic                    uf;
   logic                    pin_rise;
   logic                    pin_fall;
   logic                    pin_edge;
   logic                    pin_trig;
   logic                    trig;
   logic [7:0]              rd_mux;
   logic                    ctrl_start_nxt;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs, input logic strobe);
      hit = strobe && (a == ofs);
   endfunction

   assign wr_ctrl  = hit(reg_addr, ost_pkg::OFS_TIMER_CTRL, reg_wr);
   assign wr_shot  = hit(reg_addr, ost_pkg::OFS_SHOT_CTRL, reg_wr);
   assign wr_pin   = hit(reg_addr, ost_pkg::OFS_PIN_CTRL, reg_wr);
   assign wr_mode  = hit(reg_addr, ost_pkg::OFS_MODE, reg_wr);
   assign wr_pre   = hit(reg_addr, ost_pkg::OFS_PRESCALER, reg_wr);
   assign wr_sec   = hit(reg_addr, ost_pkg::OFS_SECONDARY, reg_wr);
   assign wr_pri   = hit(reg_addr, ost_pkg::OFS_PRIMARY, reg_wr);

   assign sw_trig  = wr_shot && reg_wdata[ost_pkg::BIT_SHOT_START];
   assign sw_stop  = wr_shot && reg_wdata[ost_pkg::BIT_SHOT_STOP];
   assign ctrl_start_nxt = reg_wdata[ost_pkg::BIT_COUNT_START] && !reg_wdata[ost_pkg::BIT_FORCED_STOP];
   assign halt     = sw_stop || (wr_ctrl && !ctrl_start_nxt);

   // The in-progress flag covers only the counting phases.
   assign in_prog  = (state_r == ost_pkg::ST_WAIT) || (state_r == ost_pkg::ST_PULSE);

   ost_cs_gen u_cs_gen (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .src_sel      (mode_r[ost_pkg::BIT_SRC_HI:ost_pkg::BIT_SRC_LO]),
      .companion_uf (companion_uf),
      .cs_tick      (cs_tick)
   );

   assign step     = in_prog && cs_tick;
   assign pre_zero = (pre_cnt_r == 8'h00);
   assign cnt_zero = (cnt_r == 8'h00);
   assign uf       = step && pre_zero && cnt_zero;

   // Edges come from the second synchroniser stage only.
   assign pin_rise = pin_s2_r && !pin_d_r;
   assign pin_fall = !pin_s2_r && pin_d_r;
   assign pin_edge = pin_ctrl_r[ost_pkg::BIT_TRIG_EDGE] ? pin_rise : pin_fall;
   assign pin_trig = pin_ctrl_r[ost_pkg::BIT_PIN_TRIG_EN] && pin_edge;
   assign trig     = (sw_trig || pin_trig) && count_running_r;

   // The interrupt side sees raw edges, whatever the timer is doing.
   assign pin_rise_pulse = pin_rise;
   assign pin_fall_pulse = pin_fall;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ost_pkg::ST_IDLE: begin
            if (trig && !halt) begin
               state_nxt = ost_pkg::ST_SYNC;
            end
         end
         ost_pkg::ST_SYNC: begin
            if (halt) begin
               state_nxt = ost_pkg::ST_IDLE;
            end else if (cs_tick) begin
               state_nxt = ost_pkg::ST_START;
            end
         end
         ost_pkg::ST_START: begin
            if (halt) begin
               state_nxt = ost_pkg::ST_IDLE;
            end else if (cs_tick && mode_r[ost_pkg::BIT_WAIT_MODE]) begin
               state_nxt = ost_pkg::ST_WAIT;
            end else if (cs_tick) begin
               state_nxt = ost_pkg::ST_PULSE;
            end
         end
         ost_pkg::ST_WAIT: begin
            if (halt) begin
               state_nxt = ost_pkg::ST_IDLE;
            end else if (uf) begin
               state_nxt = ost_pkg::ST_PULSE;
            end
         end
         ost_pkg::ST_PULSE: begin
            if (halt || uf) begin
               state_nxt = ost_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = ost_pkg::ST_IDLE;
         end
      endcase
   end

   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         ost_pkg::OFS_TIMER_CTRL: begin
            rd_mux[ost_pkg::BIT_COUNT_START]   = count_start_r;
            rd_mux[ost_pkg::BIT_COUNT_RUNNING] = count_running_r;
         end
         ost_pkg::OFS_SHOT_CTRL: begin
            rd_mux[ost_pkg::BIT_SHOT_BUSY] = in_prog;
         end
         ost_pkg::OFS_PIN_CTRL:  rd_mux = pin_ctrl_r & ost_pkg::PIN_CTRL_MASK;
         ost_pkg::OFS_MODE:      rd_mux = mode_r;
         ost_pkg::OFS_PRESCALER: rd_mux = pre_cnt_r;
         ost_pkg::OFS_SECONDARY: rd_mux = sec_rl_r;
         ost_pkg::OFS_PRIMARY:   rd_mux = cnt_r;
         default:                rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_d_r  <= 1'b1;
      end else begin
         pin_s1_r <= external_trigger_pin;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_ctrl_r      <= ost_pkg::RST_PIN_CTRL;
         mode_r          <= ost_pkg::RST_MODE;
         count_start_r   <= 1'b0;
         count_running_r <= 1'b0;
         pre_rl_r        <= ost_pkg::RST_COUNT;
         pri_rl_r        <= ost_pkg::RST_COUNT;
         sec_rl_r        <= ost_pkg::RST_COUNT;
      end else begin
         if (wr_pin) begin
            pin_ctrl_r <= reg_wdata & ost_pkg::PIN_CTRL_MASK;
         end
         if (wr_mode) begin
            mode_r <= reg_wdata;
         end
         if (wr_ctrl) begin
            count_start_r <= ctrl_start_nxt;
         end
         count_running_r <= count_start_r;
         // Reload registers always take writes; with no shot in progress the live counters take prescaler and primary writes at once, otherwise at next reload.
         if (wr_pre) begin
            pre_rl_r <= reg_wdata;
         end
         if (wr_pri) begin
            pri_rl_r <= reg_wdata;
         end
         if (wr_sec) begin
            sec_rl_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pre_cnt_r <= ost_pkg::RST_COUNT;
         cnt_r     <= ost_pkg::RST_COUNT;
      end else if (halt || (state_r == ost_pkg::ST_PULSE && uf)) begin
         pre_cnt_r <= pre_rl_r;
         cnt_r     <= pri_rl_r;
      end else if (state_r == ost_pkg::ST_WAIT && uf) begin
         pre_cnt_r <= pre_rl_r;
         cnt_r     <= sec_rl_r;
      end else if (step && pre_zero) begin
         pre_cnt_r <= pre_rl_r;
         cnt_r     <= cnt_r - 8'h01;
      end else if (step) begin
         pre_cnt_r <= pre_cnt_r - 8'h01;
      end else if (!in_prog) begin
         if (wr_pre) begin
            pre_cnt_r <= reg_wdata;
         end
         if (wr_pri) begin
            cnt_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_r <= ost_pkg::ST_IDLE;
         pulse_r <= 1'b0;
         irq_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         pulse_r <= (state_nxt == ost_pkg::ST_PULSE) ^ pin_ctrl_r[ost_pkg::BIT_OUT_LEVEL];
         irq_r   <= (state_r == ost_pkg::ST_PULSE) && uf && !halt;
         rdata_r <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign pulse_output_pin = pulse_r;
   assign timer_irq        = irq_r;
   assign reg_rdata        = rdata_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_idle_level: assert property ((state_r != ost_pkg::ST_PULSE) && $past(reset_n)
      |-> pulse_output_pin == $past(pin_ctrl_r[ost_pkg::BIT_OUT_LEVEL]))
      else $error("pulse pin not at idle level outside the pulse");
   a_pin_gated: assert property ((state_r == ost_pkg::ST_IDLE) && !sw_trig
      && !pin_ctrl_r[ost_pkg::BIT_PIN_TRIG_EN] |=> state_r == ost_pkg::ST_IDLE)
      else $error("shot started with pin trigger disabled");
   a_run_needed: assert property ((state_r == ost_pkg::ST_IDLE) && !count_running_r
      |=> state_r == ost_pkg::ST_IDLE)
      else $error("shot started while counting not running");
   a_no_retrig: assert property (in_prog && trig && !halt && !uf
      |=> state_r == $past(state_r))
      else $error("trigger changed a running shot");
   a_trig_latency: assert property ((state_r == ost_pkg::ST_IDLE) && trig && !halt
      && mode_r[ost_pkg::BIT_SRC_HI:ost_pkg::BIT_SRC_LO] == ost_pkg::SRC_F1 && !wr_mode
      |-> ##3 in_prog)
      else $error("in-progress flag late at full-rate source");
   a_wait_first: assert property ((state_r == ost_pkg::ST_START) && cs_tick && !halt
      && mode_r[ost_pkg::BIT_WAIT_MODE] |=> state_r == ost_pkg::ST_WAIT)
      else $error("wait mode did not start with the wait interval");
   a_wait_reload: assert property ((state_r == ost_pkg::ST_WAIT) && uf && !halt
      |=> (state_r == ost_pkg::ST_PULSE) && cnt_r == $past(sec_rl_r))
      else $error("secondary count not loaded after wait");
   a_end_reload: assert property ((state_r == ost_pkg::ST_PULSE) && uf
      |=> !in_prog && cnt_r == $past(pri_rl_r) && pre_cnt_r == $past(pre_rl_r))
      else $error("shot end did not reload primary");
   a_end_irq: assert property (timer_irq
      |-> $past(state_r) == ost_pkg::ST_PULSE && state_r == ost_pkg::ST_IDLE)
      else $error("timer request not at pulse end");
   a_stop_halts: assert property (sw_stop |=> state_r == ost_pkg::ST_IDLE)
      else $error("shot stop did not halt");
   a_reserved_zero: assert property (reg_rd && reg_addr == ost_pkg::OFS_PIN_CTRL
      |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved pin control bits read nonzero");
   a_plain_pulse: assert property ((state_r == ost_pkg::ST_START) && cs_tick && !halt
      && !mode_r[ost_pkg::BIT_WAIT_MODE] |=> state_r == ost_pkg::ST_PULSE)
      else $error("plain mode did not start the pulse");
   a_stop_reload: assert property (halt
      |=> state_r == ost_pkg::ST_IDLE && cnt_r == $past(pri_rl_r) && pre_cnt_r == $past(pre_rl_r))
      else $error("stop did not reload the counter");
   a_sync_fall: assert property ($fell(pin_s1_r) |=> pin_fall_pulse)
      else $error("falling pin edge lost in the synchroniser");
   a_sync_rise: assert property ($rose(pin_s1_r) |=> pin_rise_pulse)
      else $error("rising pin edge not passed to the interrupt side");

   c_plain_shot: cover property ((state_r == ost_pkg::ST_PULSE) && uf && !mode_r[ost_pkg::BIT_WAIT_MODE]);
   c_wait_shot: cover property ((state_r == ost_pkg::ST_WAIT) && uf ##[1:600] timer_irq);
   c_pin_start: cover property ((state_r == ost_pkg::ST_IDLE) && pin_trig && count_running_r);
   c_retrigger: cover property (in_prog && trig);
   c_stop_mid: cover property (in_prog && halt);

endmodule

// ---- sim/ost_trig_src.sv ----
`timescale 1ns/1ps
// Far-side trigger source on the trigger pin.
// A slow source lags each requested level change by a few cycles.
module ost_trig_src #(
   parameter int SLOW_DLY = 4
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Requested level and pace
   input  wire logic want_level,
   input  wire logic slow,
   // Pin
   output logic      external_trigger_pin
);
   logic       level_r;
   logic [3:0] lag_r;

   assign external_trigger_pin = level_r;

   // The pin idles high, as a pulled-up line does, so nothing reads as an edge after reset.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         level_r <= 1'b1;
         lag_r   <= 4'h0;
      end else if (want_level != level_r && slow && lag_r < 4'(SLOW_DLY)) begin
         lag_r <= lag_r + 4'h1;
      end else begin
         level_r <= want_level;
         lag_r   <= 4'h0;
      end
   end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   localparam logic [15:0] A_TMR  = ost_pkg::OFS_TIMER_CTRL;
   localparam logic [15:0] A_SHOT = ost_pkg::OFS_SHOT_CTRL;
   localparam logic [15:0] A_PIN  = ost_pkg::OFS_PIN_CTRL;
   localparam logic [15:0] A_MODE = ost_pkg::OFS_MODE;
   localparam logic [15:0] A_PRE  = ost_pkg::OFS_PRESCALER;
   localparam logic [15:0] A_SEC  = ost_pkg::OFS_SECONDARY;
   localparam logic [15:0] A_PRI  = ost_pkg::OFS_PRIMARY;

   logic        mclk, reset_n, reg_wr, reg_rd, companion_uf;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic        external_trigger_pin, pulse_output_pin, pin_rise_pulse, pin_fall_pulse, timer_irq;
   logic        want_level, slow, mon_en, idle_lvl, irq_end;
   logic [1:0]  comp_div;
   int          n_mismatch, check_count, cyc, act, first_act, width, n_shots, s0, t0;
   int          n_rise, n_fall, n_irq, f0, i0, r0;
   int          ratio[4] = '{1, 2, 8, 3};
   logic [15:0] stop_a[3];
   logic [7:0]  stop_d[3];

   ost_timer u_ost_timer (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .companion_uf(companion_uf),
      .external_trigger_pin(external_trigger_pin), .pulse_output_pin(pulse_output_pin),
      .pin_rise_pulse(pin_rise_pulse), .pin_fall_pulse(pin_fall_pulse), .timer_irq(timer_irq));

   ost_trig_src u_ost_trig_src (.mclk(mclk), .reset_n(reset_n), .want_level(want_level), .slow(slow),
      .external_trigger_pin(external_trigger_pin));

   always #4 mclk = ~mclk;

   // Companion underflow every third cycle, so its pulse widths differ from every divider ratio.
   always @(posedge mclk) begin
      comp_div     <= (comp_div == 2'h2) ? 2'h0 : comp_div + 2'h1;
      companion_uf <= (comp_div == 2'h2);
   end

   // Monitor: measures each pulse and counts the side outputs once per cycle.
   always begin
      @(posedge mclk);
      #1;
      cyc++;
      if (pin_rise_pulse === 1'b1) n_rise++;
      if (pin_fall_pulse === 1'b1) n_fall++;
      if (timer_irq === 1'b1) n_irq++;
      if (mon_en && pulse_output_pin !== idle_lvl) begin
         if (act == 0) first_act = cyc;
         act++;
      end else if (mon_en && act != 0) begin
         width   = act;
         irq_end = timer_irq;
         n_shots++;
         act     = 0;
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(16'(v), 16'(exp));
   endtask

   task automatic cfg(input logic [7:0] mode, input logic [7:0] pre, input logic [7:0] pri, input logic [7:0] sec);
      wr(A_MODE, mode);
      wr(A_PRE, pre);
      wr(A_SEC, sec);
      wr(A_PRI, pri);
   endtask

   task automatic trig();
      s0 = n_shots;
      wr(A_SHOT, 8'h01);
      #2 t0 = cyc;
   endtask

   task automatic no_shot();
      repeat (30) @(posedge mclk);
      chk(16'(n_shots), 16'(s0));
   endtask

   task automatic wait_shot(input int lead, input int w);
      int i;
      for (i = 0; i < 3000 && n_shots == s0; i++) @(posedge mclk);
      #2;
      if (n_shots == s0) begin
         n_mismatch++;
         $display("BAD %0t pulse never ended", $time);
         finish_test();
      end
      chk(16'(width), 16'(w));
      chk(16'(irq_end), 16'h1);
      if (lead >= 0) chk(16'(first_act - t0), 16'(lead));
      s0 = n_shots;
   endtask

   task automatic set_level(input logic v);
      mon_en = 1'b0;
      wr(A_PIN, {7'h0, v});
      repeat (3) @(posedge mclk);
      idle_lvl = v;
      act      = 0;
      mon_en   = 1'b1;
   endtask

   initial begin
      #800000;
      n_mismatch++;
      $display("BAD %0t run did not finish", $time);
      finish_test();
   end

   initial begin
      mclk = 1'b0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 16'h0000; reg_wdata = 8'h00;
      comp_div = 2'h0; companion_uf = 1'b0; want_level = 1'b1; slow = 1'b0; mon_en = 1'b1; idle_lvl = 1'b0;
      stop_a = '{A_SHOT, A_TMR, A_TMR};
      stop_d = '{8'h02, 8'h00, 8'h04};
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      rdc(A_PIN, 8'h00);
      rdc(A_MODE, 8'h00);
      rdc(16'h0100, 8'h00);
      wr(A_PIN, 8'hFF);
      rdc(A_PIN, 8'h0F);
      wr(A_PIN, 8'h00);
      cfg(8'h00, 8'h00, 8'h01, 8'h00);
      trig();
      no_shot();
      wr(A_TMR, 8'h01);
      rdc(A_TMR, 8'h03);
      trig();
      wait_shot(2, 2);
      chk(16'(pulse_output_pin), 16'h0);
      set_level(1'b1);
      chk(16'(pulse_output_pin), 16'h1);
      trig();
      wait_shot(2, 2);
      set_level(1'b0);
      cfg(8'h01, 8'h01, 8'h02, 8'h03);
      trig();
      wait_shot(8, 8);
      rdc(A_PRI, 8'h02);
      rdc(A_PRE, 8'h01);
      for (int k = 0; k < 4; k++) begin
         cfg(8'(k * 16), 8'h00, 8'h01, 8'h00);
         trig();
         wait_shot(-1, 2 * ratio[k]);
      end
      cfg(8'h00, 8'h00, 8'h09, 8'h00);
      trig();
      wr(A_SHOT, 8'h01);
      rd(A_SHOT, d);
      chk(16'(d & 8'h04), 16'h4);
      wait_shot(-1, 10);
      no_shot();
      cfg(8'h00, 8'h00, 8'h03, 8'h00);
      slow <= 1'b1;
      f0 = n_fall;
      want_level <= 1'b0;
      no_shot();
      chk(16'(n_fall - f0), 16'h1);
      want_level <= 1'b1;
      repeat (10) @(posedge mclk);
      wr(A_PIN, 8'h08);
      wr(A_PIN, 8'h0C);
      f0 = n_fall;
      want_level <= 1'b0;
      no_shot();
      chk(16'(n_fall - f0), 16'h1);
      want_level <= 1'b1;
      wait_shot(-1, 4);
      wr(A_PIN, 8'h04);
      cfg(8'h00, 8'h00, 8'h1E, 8'h00);
      f0 = n_fall;
      r0 = n_rise;
      want_level <= 1'b0;
      repeat (12) @(posedge mclk);
      want_level <= 1'b1;
      repeat (10) @(posedge mclk);
      want_level <= 1'b0;
      wait_shot(-1, 31);
      no_shot();
      chk(16'(n_fall - f0), 16'h2);
      chk(16'(n_rise - r0), 16'h1);
      cfg(8'h00, 8'h00, 8'h28, 8'h00);
      for (int j = 0; j < 3; j++) begin
         i0 = n_irq;
         trig();
         repeat (8) @(posedge mclk);
         wr(stop_a[j], stop_d[j]);
         repeat (4) @(posedge mclk);
         chk(16'(pulse_output_pin), 16'h0);
         chk(16'(n_irq - i0), 16'h0);
         rd(A_SHOT, d);
         chk(16'(d & 8'h04), 16'h0);
         rdc(A_PRI, 8'h28);
         wr(A_TMR, 8'h01);
      end
      finish_test();
   end
endmodule
